// ### rtl/nbi_fault_rec.sv
// Bus-fault cause classifier and recorder
`timescale 1ns/1ps
module nbi_fault_rec #(
	parameter logic [31:0] RAM_TOP = 32'h20003fff,
	parameter logic [31:0] FLASH_TOP = 32'h0003ffff
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Monitored access
	input wire logic acc_valid_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic [1:0] acc_size_i,
	input wire logic acc_write_i,
	input wire logic acc_priv_i,
	input wire logic acc_apb_i,
	input wire logic acc_sys_periph_i,
	input wire logic acc_prot_ram_i,
	input wire logic acc_ram_i,
	input wire logic acc_flash_i,
	input wire logic [11:0] acc_last_reg_i,
	// Software clear of the recorded causes
	input wire logic clear_i,
	input wire logic [3:0] clear_bits_i,
	// Results
	output logic [3:0] status_o,
	output logic bus_fault_o,
	output logic hard_fault_o
);
	logic [3:0] cause;
	logic any;
	logic second;

	// Classify one access into cause bits; several may be set at once
	always_comb begin
		cause = 4'h0;
		if (acc_valid_i) begin
			if ((acc_apb_i && acc_size_i != 2'h2) ||
			    (acc_size_i == 2'h2 && acc_addr_i[1:0] != 2'h0)) begin
				cause[nbi_pkg::FAULT_SIZE_BIT] = 1'b1;
			end
			if (acc_write_i && !acc_priv_i && (acc_sys_periph_i || acc_prot_ram_i)) begin
				cause[nbi_pkg::FAULT_PROT_BIT] = 1'b1;
			end
			if ((acc_apb_i && (acc_addr_i & nbi_pkg::PERIPH_BLOCK_MASK) >
			     {20'h00000, acc_last_reg_i}) ||
			    (acc_ram_i && acc_addr_i > RAM_TOP) ||
			    (acc_flash_i && acc_addr_i > FLASH_TOP)) begin
				cause[nbi_pkg::FAULT_RSVD_BIT] = 1'b1;
			end
		end
	end

	assign any = |cause[2:0];
	// A fault while causes are still recorded is a second fault
	assign second = any && (|status_o[2:0]);

	// Record causes, set wins over clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_o <= 4'h0;
		end else begin
			status_o <= (status_o & ~(clear_i ? clear_bits_i : 4'h0)) | cause |
			            {second, 3'h0};
		end
	end

	// Bus fault pulse, preempted by a hard fault on a second fault
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_fault_o <= 1'b0;
			hard_fault_o <= 1'b0;
		end else begin
			bus_fault_o <= any && !second;
			hard_fault_o <= second;
		end
	end
endmodule

// ### rtl/nbi_pkg.sv
// Package of constants for the non-maskable, bus-fault and line-enable glue
package nbi_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [31:0] IRQ_ENABLE_SET_ADDR = 32'he000e100;
	localparam logic [31:0] IRQ_ENABLE_CLEAR_ADDR = 32'he000e180;
	localparam logic [31:0] AUX_FAULT_STATUS_ADDR = 32'he000e300;
	localparam logic [31:0] EVENT_STATUS_ADDR = 32'he000e310;
	localparam logic [31:0] EVENT_ENABLE_ADDR = 32'he000e314;
	localparam logic [31:0] EVENT_CLEAR_ADDR = 32'he000e318;
	localparam logic [31:0] CLOCK_STATUS_ADDR = 32'he000e320;
	localparam logic [31:0] WATCHDOG_CTRL_ADDR = 32'he000e324;
	localparam logic [31:0] WATCHDOG_RESTART_ADDR = 32'he000e328;
	// ****************************************************************
	// Field layout and reset values
	// ****************************************************************
	localparam int LINE_COUNT = 20;
	localparam logic [19:0] IRQ_ENABLE_RESET = 20'h00000;
	localparam int FAULT_SIZE_BIT = 0;
	localparam int FAULT_PROT_BIT = 1;
	localparam int FAULT_RSVD_BIT = 2;
	localparam int FAULT_MISSED_BIT = 3;
	localparam int EVT_CRYSTAL_BIT = 0;
	localparam int EVT_WATCHDOG_BIT = 1;
	localparam int EVT_BUSFAULT_BIT = 2;
	localparam int EVT_HARDFAULT_BIT = 3;
	localparam logic [31:0] PERIPH_BLOCK_MASK = 32'h00000fff;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 25000000;
	localparam int WATCHDOG_TIME_MS = 1792;
	localparam longint WATCHDOG_CYCLES = longint'(CLK_HZ) * WATCHDOG_TIME_MS / 1000;
	localparam int SWITCH_SETTLE_CYCLES = 4;
	// Clock switch sequence
	typedef enum logic [1:0] {
		NBI_CLK_CRYSTAL = 2'h0,
		NBI_CLK_DETECT = 2'h1,
		NBI_CLK_SWITCH = 2'h3,
		NBI_CLK_RC = 2'h2
	} nbi_clk_state_type;
endpackage

// ### rtl/nbi_top.sv
// Top of the non-maskable, bus-fault and line-enable glue with AXI4-Lite slave
`timescale 1ns/1ps
module nbi_top #(
	parameter longint WATCHDOG_CYCLES = nbi_pkg::WATCHDOG_CYCLES,
	parameter int LINES = nbi_pkg::LINE_COUNT
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// AXI4-Lite write address and data
	input wire logic [31:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Peripheral lines and core side
	input wire logic [19:0] periph_irq_i,
	output logic [19:0] core_irq_o,
	output logic nmi_o,
	output logic bus_fault_o,
	output logic hard_fault_o,
	output logic irq_o,
	// Clock supervision
	input wire logic crystal_ok_i,
	output logic clk_sel_rc_o,
	// Monitored system-bus access
	input wire logic acc_valid_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic [1:0] acc_size_i,
	input wire logic acc_write_i,
	input wire logic acc_priv_i,
	input wire logic acc_apb_i,
	input wire logic acc_sys_periph_i,
	input wire logic acc_prot_ram_i,
	input wire logic acc_ram_i,
	input wire logic acc_flash_i,
	input wire logic [11:0] acc_last_reg_i
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [LINES-1:0] irq_enable;
	logic [3:0] aux_fault_status;
	logic [3:0] event_status;
	logic [3:0] event_enable;
	logic [3:0] next_event_status;
	logic [3:0] event_pulse;
	logic wd_active;
	logic [31:0] wd_count;
	logic wd_fire;
	logic crystal_failure_event;
	logic [2:0] settle_count;
	nbi_pkg::nbi_clk_state_type clk_state;
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [31:0] wmask;
	logic fault_clear;

	// Byte-lane mask from write strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// Decode of mapped addresses, used by both channels
	function automatic logic is_mapped(input logic [31:0] a);
		if (a == nbi_pkg::IRQ_ENABLE_SET_ADDR) begin
			is_mapped = 1'b1;
		end else if (a == nbi_pkg::IRQ_ENABLE_CLEAR_ADDR) begin
			is_mapped = 1'b1;
		end else if (a == nbi_pkg::AUX_FAULT_STATUS_ADDR) begin
			is_mapped = 1'b1;
		end else if (a == nbi_pkg::EVENT_STATUS_ADDR || a == nbi_pkg::EVENT_ENABLE_ADDR) begin
			is_mapped = 1'b1;
		end else if (a == nbi_pkg::EVENT_CLEAR_ADDR || a == nbi_pkg::CLOCK_STATUS_ADDR) begin
			is_mapped = 1'b1;
		end else if (a == nbi_pkg::WATCHDOG_CTRL_ADDR) begin
			is_mapped = 1'b1;
		end else begin
			is_mapped = (a == nbi_pkg::WATCHDOG_RESTART_ADDR);
		end
	endfunction

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	assign s_axi_awready_o = !aw_held;
	assign s_axi_wready_o = !w_held;
	assign wr_go = aw_held && w_held && !s_axi_bvalid_o;
	assign wmask = w_data & lane_mask(w_strb);

	// Capture address and data in either order
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid_i && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response
	// A held answer keeps wr_go low, so writes never overlap
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= nbi_pkg::AXI_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= is_mapped(aw_addr) ? nbi_pkg::AXI_OKAY : nbi_pkg::AXI_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Line enables
	// ****************************************************************
	// Set and clear by writing ones; upper bits dropped
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_enable <= nbi_pkg::IRQ_ENABLE_RESET[LINES-1:0];
		end else if (wr_go && aw_addr == nbi_pkg::IRQ_ENABLE_SET_ADDR) begin
			irq_enable <= irq_enable | wmask[LINES-1:0];
		end else if (wr_go && aw_addr == nbi_pkg::IRQ_ENABLE_CLEAR_ADDR) begin
			irq_enable <= irq_enable & ~wmask[LINES-1:0];
		end
	end

	// Each bit position gates its own peripheral line
	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : gen_line
			assign core_irq_o[g] = periph_irq_i[g] & irq_enable[g];
		end
	endgenerate

	// ****************************************************************
	// Crystal supervision and clock switch
	// ****************************************************************
	// Detection is one-shot: the rc state holds until reset
	// The event waits for the settle count so software sees a stable clock
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_state <= nbi_pkg::NBI_CLK_CRYSTAL;
			settle_count <= 3'h0;
			clk_sel_rc_o <= 1'b0;
			crystal_failure_event <= 1'b0;
		end else begin
			crystal_failure_event <= 1'b0;
			case (clk_state)
				nbi_pkg::NBI_CLK_CRYSTAL: begin
					if (!crystal_ok_i) begin
						clk_state <= nbi_pkg::NBI_CLK_DETECT;
					end
				end
				nbi_pkg::NBI_CLK_DETECT: begin
					clk_sel_rc_o <= 1'b1;
					settle_count <= 3'h0;
					clk_state <= nbi_pkg::NBI_CLK_SWITCH;
				end
				nbi_pkg::NBI_CLK_SWITCH: begin
					settle_count <= settle_count + 3'h1;
					if (settle_count == 3'(nbi_pkg::SWITCH_SETTLE_CYCLES - 1)) begin
						crystal_failure_event <= 1'b1;
						clk_state <= nbi_pkg::NBI_CLK_RC;
					end
				end
				default: begin
					clk_state <= nbi_pkg::NBI_CLK_RC;
				end
			endcase
		end
	end

	// ****************************************************************
	// Watchdog timeout counter
	// ****************************************************************
	// Count only while active; a restart write or a fire starts again
	assign wd_fire = wd_active && (wd_count == 32'(WATCHDOG_CYCLES - 1));

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wd_active <= 1'b0;
			wd_count <= 32'h0;
		end else begin
			if (wr_go && aw_addr == nbi_pkg::WATCHDOG_CTRL_ADDR && w_strb[0]) begin
				wd_active <= w_data[0];
			end
			if (!wd_active || (wr_go && aw_addr == nbi_pkg::WATCHDOG_RESTART_ADDR)) begin
				wd_count <= 32'h0;
			end else if (wd_fire) begin
				wd_count <= 32'h0;
			end else begin
				wd_count <= wd_count + 32'h1;
			end
		end
	end

	// ****************************************************************
	// Bus-fault recorder
	// ****************************************************************
	assign fault_clear = wr_go && aw_addr == nbi_pkg::AUX_FAULT_STATUS_ADDR;

	nbi_fault_rec u_fault (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.acc_valid_i(acc_valid_i),
		.acc_addr_i(acc_addr_i),
		.acc_size_i(acc_size_i),
		.acc_write_i(acc_write_i),
		.acc_priv_i(acc_priv_i),
		.acc_apb_i(acc_apb_i),
		.acc_sys_periph_i(acc_sys_periph_i),
		.acc_prot_ram_i(acc_prot_ram_i),
		.acc_ram_i(acc_ram_i),
		.acc_flash_i(acc_flash_i),
		.acc_last_reg_i(acc_last_reg_i),
		.clear_i(fault_clear),
		.clear_bits_i(wmask[3:0]),
		.status_o(aux_fault_status),
		.bus_fault_o(bus_fault_o),
		.hard_fault_o(hard_fault_o)
	);

	// ****************************************************************
	// Event manager and NMI
	// ****************************************************************
	assign event_pulse = {hard_fault_o, bus_fault_o, wd_fire, crystal_failure_event};

	// Sticky event bits, set wins over clear
	always_comb begin
		next_event_status = event_status;
		if (wr_go && aw_addr == nbi_pkg::EVENT_CLEAR_ADDR) begin
			next_event_status = event_status & ~wmask[3:0];
		end
		next_event_status = next_event_status | event_pulse;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			event_status <= 4'h0;
			event_enable <= 4'h0;
		end else begin
			event_status <= next_event_status;
			if (wr_go && aw_addr == nbi_pkg::EVENT_ENABLE_ADDR) begin
				// Only lane 0 carries the four enable bits
				event_enable <= w_strb[0] ? wmask[3:0] : event_enable;
			end
		end
	end

	// NMI is not maskable: either second-level source raises it
	assign nmi_o = event_status[nbi_pkg::EVT_CRYSTAL_BIT] |
	               event_status[nbi_pkg::EVT_WATCHDOG_BIT];
	assign irq_o = |(event_status & event_enable);

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	// A new read is taken only once the last answer is gone
	assign s_axi_arready_o = !s_axi_rvalid_o;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= nbi_pkg::AXI_OKAY;
		end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= nbi_pkg::AXI_OKAY;
			s_axi_rdata_o <= 32'h0;
			if (s_axi_araddr_i == nbi_pkg::IRQ_ENABLE_SET_ADDR ||
			    s_axi_araddr_i == nbi_pkg::IRQ_ENABLE_CLEAR_ADDR) begin
				s_axi_rdata_o <= 32'(irq_enable);
			end else if (s_axi_araddr_i == nbi_pkg::AUX_FAULT_STATUS_ADDR) begin
				s_axi_rdata_o <= {28'h0, aux_fault_status};
			end else if (s_axi_araddr_i == nbi_pkg::EVENT_STATUS_ADDR) begin
				s_axi_rdata_o <= {28'h0, event_status};
			end else if (s_axi_araddr_i == nbi_pkg::EVENT_ENABLE_ADDR) begin
				s_axi_rdata_o <= {28'h0, event_enable};
			end else if (s_axi_araddr_i == nbi_pkg::CLOCK_STATUS_ADDR) begin
				s_axi_rdata_o <= {30'h0, clk_state == nbi_pkg::NBI_CLK_RC, clk_sel_rc_o};
			end else if (s_axi_araddr_i == nbi_pkg::WATCHDOG_CTRL_ADDR) begin
				s_axi_rdata_o <= {31'h0, wd_active};
			end else if (!is_mapped(s_axi_araddr_i)) begin
				s_axi_rresp_o <= nbi_pkg::AXI_SLVERR;
			end
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end
endmodule

// ### sim/nbi_checker.sv
// Checker for the glue's port behaviour
`timescale 1ns/1ps
module nbi_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Lines and supervision
	input wire logic [19:0] periph_irq_i,
	input wire logic [19:0] core_irq_o,
	input wire logic nmi_o,
	input wire logic crystal_ok_i,
	input wire logic clk_sel_rc_o,
	// Faults
	input wire logic bus_fault_o,
	input wire logic hard_fault_o,
	input wire logic acc_valid_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic [1:0] acc_size_i,
	input wire logic acc_write_i,
	input wire logic acc_priv_i,
	input wire logic acc_apb_i,
	input wire logic acc_sys_periph_i,
	// Read channel
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_arready_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// ****************************************************************
	// Properties
	// ****************************************************************
	line_gate_a: assert property ((core_irq_o & ~periph_irq_i) == 20'h00000)
		else $error("line passed while source low");
	rc_switch_a: assert property (!crystal_ok_i && !clk_sel_rc_o |-> ##[1:2] clk_sel_rc_o)
		else $error("no switch to rc clock");
	rc_sticky_a: assert property (clk_sel_rc_o |=> clk_sel_rc_o)
		else $error("rc selection dropped");
	nmi_after_a: assert property ($rose(clk_sel_rc_o) && !nmi_o |-> !nmi_o [*3] ##[1:4] nmi_o)
		else $error("crystal nmi timing wrong");
	size_fault_a: assert property (acc_valid_i && acc_apb_i && acc_size_i != 2'h2
		|=> bus_fault_o || hard_fault_o)
		else $error("narrow access not faulted");
	align_fault_a: assert property (acc_valid_i && acc_size_i == 2'h2 && acc_addr_i[1:0] != 2'h0
		|=> bus_fault_o || hard_fault_o)
		else $error("unaligned word not faulted");
	prot_fault_a: assert property (acc_valid_i && acc_write_i && !acc_priv_i && acc_sys_periph_i
		|=> bus_fault_o || hard_fault_o)
		else $error("user write not faulted");
	fault_cause_a: assert property (bus_fault_o || hard_fault_o |-> $past(acc_valid_i))
		else $error("fault without access");
	hard_only_a: assert property (hard_fault_o |-> !bus_fault_o)
		else $error("bus fault beside hard fault");
	read_hold_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while answer held");
	// Main scenarios reached
	cov_switch: cover property ($rose(clk_sel_rc_o));
	cov_hard: cover property (hard_fault_o);
	cov_nmi: cover property ($rose(nmi_o));
endmodule

// ### sim/nbi_partner.sv
// Peripheral sources and crystal supervisor model
`timescale 1ns/1ps
module nbi_partner (
	// Clock
	input wire logic clk_i,
	// Peripheral levels and crystal state
	output logic [19:0] periph_irq_o,
	output logic crystal_ok_o
);
	// Quiet lines, healthy crystal at start
	initial begin
		periph_irq_o = 20'h00000;
		crystal_ok_o = 1'b1;
	end
	// Lines change just after an edge
	task automatic lines(input logic [19:0] v);
		@(posedge clk_i);
		periph_irq_o <= v;
	endtask
	// Crystal dies and stays dead
	task automatic fail();
		@(posedge clk_i);
		crystal_ok_o <= 1'b0;
	endtask
endmodule

// ### sim/nbi_top_bench.sv
// Testbench of the glue
`timescale 1ns/1ps
module nbi_top_bench;
	localparam logic [31:0] SET = nbi_pkg::IRQ_ENABLE_SET_ADDR;
	localparam logic [31:0] CLR = nbi_pkg::IRQ_ENABLE_CLEAR_ADDR;
	localparam logic [31:0] AUX = nbi_pkg::AUX_FAULT_STATUS_ADDR;
	localparam logic [31:0] EST = nbi_pkg::EVENT_STATUS_ADDR;
	localparam logic [31:0] EEN = nbi_pkg::EVENT_ENABLE_ADDR;
	localparam logic [31:0] ECL = nbi_pkg::EVENT_CLEAR_ADDR;
	localparam logic [1:0] OK = nbi_pkg::AXI_OKAY;
	localparam logic [1:0] ERR = nbi_pkg::AXI_SLVERR;
	logic clk_i, rst_b_i, awv, awr, wv, wrdy, bv, arv, arr, rv, av, aw, ap, aapb, asys, ar;
	logic nmi, bf, hf, irq, sel, cok, brdy, rrdy;
	logic [31:0] awa, wd, ara, rdat, aa, e;
	logic [1:0] br, rr, asz;
	logic [11:0] lr;
	logic [19:0] pl, ci;
	int failures, comparisons, i, n;
	nbi_partner p (.clk_i(clk_i), .periph_irq_o(pl), .crystal_ok_o(cok));
	nbi_top #(.WATCHDOG_CYCLES(20)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy),
		.periph_irq_i(pl), .core_irq_o(ci), .nmi_o(nmi), .bus_fault_o(bf),
		.hard_fault_o(hf), .irq_o(irq), .crystal_ok_i(cok), .clk_sel_rc_o(sel),
		.acc_valid_i(av), .acc_addr_i(aa), .acc_size_i(asz), .acc_write_i(aw),
		.acc_priv_i(ap), .acc_apb_i(aapb), .acc_sys_periph_i(asys), .acc_prot_ram_i(1'b0),
		.acc_ram_i(ar), .acc_flash_i(1'b0), .acc_last_reg_i(lr));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic expire();
		failures++;
		$display("unexpected wait expected answer seen none");
		end_sim();
	endtask
	// Bus write: address and data together, each released when taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] x);
		logic ta, tw, b;
		logic [1:0] r;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		b = 1'b0;
		for (int k = 0; k < 50 && !b; k++) begin
			@(negedge clk_i);
			ta = awv && awr;
			tw = wv && wrdy;
			b = bv;
			r = br;
			@(posedge clk_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (ta || tw) brdy <= 1'b1;
		end
		brdy <= 1'b0;
		if (!b) expire();
		chk("bresp", 32'(r), 32'(x));
	endtask
	// Bus read with expected data and response
	task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [1:0] xr);
		logic t, g;
		logic [31:0] v;
		logic [1:0] r;
		ara <= a;
		arv <= 1'b1;
		g = 1'b0;
		for (int k = 0; k < 50 && !g; k++) begin
			@(negedge clk_i);
			t = arv && arr;
			g = rv;
			v = rdat;
			r = rr;
			@(posedge clk_i);
			if (t) arv <= 1'b0;
			if (t) rrdy <= 1'b1;
		end
		rrdy <= 1'b0;
		if (!g) expire();
		chk("rdata", v, x);
		chk("rresp", 32'(r), 32'(xr));
	endtask
	// One-cycle monitored access; f is write, priv, apb, sys, ram
	task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic [4:0] f);
		@(posedge clk_i);
		aa <= a;
		asz <= s;
		{aw, ap, aapb, asys, ar} <= f;
		av <= 1'b1;
		@(posedge clk_i);
		av <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	// ****************************************************************
	// Clock, limit and sequence
	// ****************************************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		#2000000;
		expire();
	end
	initial begin
		{rst_b_i, awv, wv, arv, av, aw, ap, aapb, asys, ar, brdy, rrdy} = '0;
		{awa, wd, ara, aa, asz} = '0;
		lr = 12'h0ff;
		failures = 0;
		comparisons = 0;
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		rd(SET, 32'h0, OK);
		rd(CLR, 32'h0, OK);
		p.lines(20'hfffff);
		@(negedge clk_i);
		chk("core_irq", 32'(ci), 32'h0);
		@(posedge clk_i);
		$display("test reset done");
		e = 32'h0;
		for (i = 0; i < 20; i++) begin
			wr(SET, 32'h1 << i, OK);
			e = e | (32'h1 << i);
			rd(SET, e, OK);
			chk("core_irq", 32'(ci), e);
		end
		wr(SET, 32'hfff00000, OK);
		rd(SET, 32'h000fffff, OK);
		for (i = 0; i < 20; i++) begin
			wr(CLR, 32'h1 << i, OK);
			e = e & ~(32'h1 << i);
			rd(CLR, e, OK);
			chk("core_irq", 32'(ci), e);
		end
		wr(32'he000e3f0, 32'h1, ERR);
		rd(32'he000e3f0, 32'h0, ERR);
		$display("test enables done");
		wr(EEN, 32'h4, OK);
		acc(32'h40000010, 2'h0, 5'b00100);
		rd(AUX, 32'h1, OK);
		chk("irq", 32'(irq), 32'h1);
		rd(EST, 32'h4, OK);
		acc(32'h40000010, 2'h0, 5'b00100);
		rd(AUX, 32'h9, OK);
		rd(EST, 32'hc, OK);
		wr(EEN, 32'h0, OK);
		chk("irq", 32'(irq), 32'h0);
		wr(EEN, 32'h4, OK);
		chk("irq", 32'(irq), 32'h1);
		wr(ECL, 32'hc, OK);
		chk("irq", 32'(irq), 32'h0);
		wr(AUX, 32'hf, OK);
		rd(AUX, 32'h0, OK);
		acc(32'h40000010, 2'h2, 5'b10010);
		rd(AUX, 32'h2, OK);
		wr(AUX, 32'hf, OK);
		acc(32'h40000200, 2'h1, 5'b01100);
		rd(AUX, 32'h5, OK);
		wr(AUX, 32'hf, OK);
		acc(32'h20000002, 2'h2, 5'b01001);
		rd(AUX, 32'h1, OK);
		wr(AUX, 32'hf, OK);
		wr(ECL, 32'hc, OK);
		$display("test faults done");
		p.fail();
		for (n = 0; n < 20 && nmi !== 1'b1; n++) @(negedge clk_i);
		if (nmi !== 1'b1) expire();
		chk("clk_sel", 32'(sel), 32'h1);
		chk("nmi", 32'(nmi), 32'h1);
		@(posedge clk_i);
		rd(EST, 32'h1, OK);
		rd(nbi_pkg::CLOCK_STATUS_ADDR, 32'h3, OK);
		wr(ECL, 32'h1, OK);
		chk("nmi", 32'(nmi), 32'h0);
		wr(nbi_pkg::WATCHDOG_CTRL_ADDR, 32'h1, OK);
		for (i = 0; i < 8; i++) wr(nbi_pkg::WATCHDOG_RESTART_ADDR, 32'h0, OK);
		chk("nmi", 32'(nmi), 32'h0);
		for (n = 0; n < 60 && nmi !== 1'b1; n++) @(negedge clk_i);
		if (nmi !== 1'b1) expire();
		chk("nmi", 32'(nmi), 32'h1);
		@(posedge clk_i);
		rd(EST, 32'h2, OK);
		wr(nbi_pkg::WATCHDOG_CTRL_ADDR, 32'h0, OK);
		wr(ECL, 32'h2, OK);
		chk("nmi", 32'(nmi), 32'h0);
		$display("test nmi done");
		end_sim();
	end
endmodule
bind nbi_top nbi_checker chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.periph_irq_i(periph_irq_i), .core_irq_o(core_irq_o), .nmi_o(nmi_o),
	.crystal_ok_i(crystal_ok_i), .clk_sel_rc_o(clk_sel_rc_o), .bus_fault_o(bus_fault_o),
	.hard_fault_o(hard_fault_o), .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i),
	.acc_size_i(acc_size_i), .acc_write_i(acc_write_i), .acc_priv_i(acc_priv_i),
	.acc_apb_i(acc_apb_i), .acc_sys_periph_i(acc_sys_periph_i),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_arready_o(s_axi_arready_o));
